// file: src/dspea_map.svh
// Address map and field constants for the data-space paging and address generator.
// Assumes inclusion by the package and the design file; definitions only.
`ifndef DSPEA_MAP_SVH
`define DSPEA_MAP_SVH

`define DSPEA_PAGE_RESET     10'h001
`define DSPEA_PAGE_ZERO      10'h000
`define DSPEA_WIN_BIT        15
`define DSPEA_NEAR_BITS      13
`define DSPEA_LIT_SHORT      5
`define DSPEA_LIT_LONG       10
`define DSPEA_OFF_BITS       15
`define DSPEA_DEFAULT_DEFAULT_WORK_REGISTER   4'h0

`endif

// file: src/dspea_pkg.sv
// Types for the data-space paging and effective-address generator.
// Assumes dspea_map.svh sits beside it on the include path.
`include "dspea_map.svh"

package dspea_pkg;

	typedef enum logic [2:0] {
		ModeFileDirect,
		ModeRegDirect,
		ModeIndirect,
		ModePostMod,
		ModePreMod,
		ModeIndexed,
		ModeLitOffset,
		ModeLiteral
	} dspea_mode_t;

	typedef struct packed {
		logic            valid;
		dspea_mode_t     mode;
		logic            isWrite;
		logic            isMove;
		logic            longLit;
		logic [3:0]      ptrSel;
		logic [15:0]     pointerValue;
		logic [15:0]     baseOperandValue;
		logic [15:0]     fileAddr;
		logic [15:0]     modConst;
		logic [9:0]      literal;
	} dspea_req_t;

	typedef struct packed {
		logic            valid;
		logic [23:0]     extAddr;
		logic [15:0]     effectiveAddress;
		logic            isWrite;
		logic            isLiteral;
		logic [15:0]     literalValue;
		logic            ptrUpdate;
		logic [3:0]      ptrSel;
		logic [15:0]     ptrNewValue;
		logic [3:0]      defaultWorkReg;
		logic            addrErrorTrap;
	} dspea_rsp_t;

endpackage

// file: src/dspea_gen.sv
// Effective-address generation and extended data paging for data operands.
// Assumes the core presents one decoded operand request per cycle.
// What this block does
// - Base 0x0000-0x7FFF passes straight through
// - Bit 15 clear lands on extended page 0
// - Reset loads both page registers with 0x001
// - Upper window with page register 0 raises trap; page 0x200 reaches page 0 untrapped
// - Software write of zero leaves page unchanged
// - Nonzero pages only via upper window plus page
// - Upper window maps linearly by page number modulo 512
// - File-register direct field is 13 bits
// - Default working register is W0
// - Move instruction reaches whole data space
// - Three-operand first source is a working register
// - Literals are 5 or 10 bits
// - File direct address comes from instruction
// - Indirect address is pointer contents
// - Post-modify uses pointer, then adjusts it
// - Pre-modify adjusts pointer, then uses it
// - Indexed address is pointer plus base operand
// - Literal offset is pointer plus literal
`timescale 1ns/100ps
`include "dspea_map.svh"

module dspea_gen #(
	parameter int PAGE_W = 10
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire dspea_pkg::dspea_req_t req,
	input  wire logic                pageWrRead,
	input  wire logic                pageWrWrite,
	input  wire logic [PAGE_W-1:0]   pageWrData,
	output dspea_pkg::dspea_rsp_t    rsp,
	output logic [PAGE_W-1:0]        dataReadPage,
	output logic [PAGE_W-1:0]        dataWritePage
);
	import dspea_pkg::*;

	logic [PAGE_W-1:0] readPage_q;
	logic [PAGE_W-1:0] writePage_q;
	dspea_rsp_t        rsp_q;
	dspea_rsp_t        rsp_d;
	logic [15:0]       ea;
	logic [15:0]       litExt;
	logic [PAGE_W-1:0] selPage;

	// Zero writes are dropped so neither page register holds 0; page 0x200 still maps the upper window onto page 0
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			readPage_q <= PAGE_W'(`DSPEA_PAGE_RESET);
		end else if (pageWrRead && pageWrData != PAGE_W'(`DSPEA_PAGE_ZERO)) begin
			readPage_q <= pageWrData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			writePage_q <= PAGE_W'(`DSPEA_PAGE_RESET);
		end else if (pageWrWrite && pageWrData != PAGE_W'(`DSPEA_PAGE_ZERO)) begin
			writePage_q <= pageWrData;
		end
	end

	always_comb begin
		if (req.longLit) begin
			litExt = {6'h00, req.literal};
		end else begin
			litExt = {11'h000, req.literal[`DSPEA_LIT_SHORT-1:0]};
		end
	end

	always_comb begin
		rsp_d = '0;
		ea = req.pointerValue;
		rsp_d.ptrSel = req.ptrSel;
		rsp_d.ptrNewValue = req.pointerValue;
		rsp_d.defaultWorkReg = `DSPEA_DEFAULT_DEFAULT_WORK_REGISTER;
		rsp_d.isWrite = req.isWrite;
		case (req.mode)
			ModeFileDirect: begin
				if (req.isMove) begin
					ea = req.fileAddr;
				end else begin
					ea = {3'h0, req.fileAddr[`DSPEA_NEAR_BITS-1:0]};
				end
			end
			ModeRegDirect: begin
				ea = req.baseOperandValue;
			end
			ModeIndirect: begin
				ea = req.pointerValue;
			end
			ModePostMod: begin
				ea = req.pointerValue;
				rsp_d.ptrUpdate = 1'b1;
				rsp_d.ptrNewValue = req.pointerValue + req.modConst;
			end
			ModePreMod: begin
				ea = req.pointerValue + req.modConst;
				rsp_d.ptrUpdate = 1'b1;
				rsp_d.ptrNewValue = ea;
			end
			ModeIndexed: begin
				ea = req.pointerValue + req.baseOperandValue;
			end
			ModeLitOffset: begin
				ea = req.pointerValue + litExt;
			end
			ModeLiteral: begin
				ea = req.baseOperandValue;
				rsp_d.isLiteral = 1'b1;
				rsp_d.literalValue = litExt;
			end
			default: begin
				ea = req.pointerValue;
			end
		endcase
		rsp_d.effectiveAddress = ea;
		selPage = req.isWrite ? writePage_q : readPage_q;
		if (!ea[`DSPEA_WIN_BIT]) begin
			rsp_d.extAddr = {8'h00, ea};
		end else begin
			// Page n covers (n mod 512)*32K .. (n mod 512)*32K+32K-1
			rsp_d.extAddr = 24'({selPage, ea[`DSPEA_OFF_BITS-1:0]});
			rsp_d.addrErrorTrap = (selPage == PAGE_W'(`DSPEA_PAGE_ZERO));
		end
		rsp_d.valid = req.valid && !rsp_d.isLiteral;
		if (!req.valid) begin
			rsp_d.ptrUpdate = 1'b0;
			rsp_d.addrErrorTrap = 1'b0;
		end
		if (rsp_d.addrErrorTrap) begin
			rsp_d.valid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	assign rsp = rsp_q;
	assign dataReadPage = readPage_q;
	assign dataWritePage = writePage_q;

	sequence s_upperAccess;
		req.valid && req.mode != ModeLiteral && rsp_d.effectiveAddress[15];
	endsequence

	chk_page_never_zero: assert property (@(posedge clk_sys) disable iff (rst)
		readPage_q != '0 && writePage_q != '0)
		else $error("page register reached zero");
	chk_reset_page_one: assert property (@(posedge clk_sys)
		$past(rst) |-> readPage_q == PAGE_W'(`DSPEA_PAGE_RESET)
		&& writePage_q == PAGE_W'(`DSPEA_PAGE_RESET))
		else $error("page not one after reset");
	chk_low_direct_map: assert property (@(posedge clk_sys) disable iff (rst)
		rsp_d.valid && !rsp_d.effectiveAddress[15] |=> rsp.extAddr[23:16] == 8'h00
		&& rsp.extAddr[15:0] == rsp.effectiveAddress)
		else $error("low window not direct");
	chk_upper_linear: assert property (@(posedge clk_sys) disable iff (rst)
		s_upperAccess |=> rsp.extAddr[23:15] == 9'(rsp.isWrite ? $past(writePage_q)
		: $past(readPage_q)))
		else $error("upper window page mismatch");
	chk_trap_page_zero: assert property (@(posedge clk_sys) disable iff (rst)
		rsp.addrErrorTrap |-> rsp.extAddr[23:15] == 9'h000 && !rsp.valid)
		else $error("trap without page zero");
	chk_post_modify: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && req.mode == ModePostMod |=> rsp.ptrUpdate
		&& rsp.effectiveAddress == $past(req.pointerValue))
		else $error("post modify wrong");
	chk_pre_modify: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && req.mode == ModePreMod |=> rsp.ptrNewValue == rsp.effectiveAddress
		&& rsp.ptrUpdate)
		else $error("pre modify wrong");
	chk_indexed_sum: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && req.mode == ModeIndexed |=> rsp.effectiveAddress
		== 16'($past(req.pointerValue) + $past(req.baseOperandValue)))
		else $error("indexed sum wrong");
	chk_near_field: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && req.mode == ModeFileDirect && !req.isMove
		|=> rsp.effectiveAddress[15:13] == 3'h0)
		else $error("near field exceeds 13 bits");

endmodule

// file: dv/dspea_core_model.sv
// Core-side model: presents one decoded operand request per call.
// Assumes callers sit just after a rising edge of clk_sys.
`timescale 1ns/100ps

module dspea_core_model (
	input  wire logic           clk_sys,
	output dspea_pkg::dspea_req_t req
);
	import dspea_pkg::*;
	initial req = '0;
	// Held until the taking edge has passed
	task automatic send(input dspea_req_t r);
		req = r;
		@(posedge clk_sys);
		#1;
	endtask
	// Released fields show inverted junk, never the old value
	task automatic idle();
		dspea_req_t z;
		z = dspea_req_t'(~req);
		z.valid = 1'b0;
		req = z;
	endtask
endmodule

// file: dv/tb_top.sv
// Bench for the paging and address generator: requests, page writes, checks.
// Assumes the src package and generator are compiled first.
`timescale 1ns/100ps

module tb_top;
	import dspea_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       pageWrRead = 1'b0;
	logic       pageWrWrite = 1'b0;
	logic [9:0] pageWrData = 10'h000;
	logic [9:0] rdPage;
	logic [9:0] wrPage;
	dspea_req_t req;
	dspea_rsp_t rsp;
	int         err_count = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	always #25 clk_sys = ~clk_sys;

	dspea_core_model u_core (.clk_sys(clk_sys), .req(req));
	dspea_gen #(.PAGE_W(10)) u_dut (.clk_sys(clk_sys), .rst(rst), .req(req),
		.pageWrRead(pageWrRead), .pageWrWrite(pageWrWrite), .pageWrData(pageWrData),
		.rsp(rsp), .dataReadPage(rdPage), .dataWritePage(wrPage));

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask

	task automatic give_verdict();
		$display("Mismatches %0d of %0d comparisons", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Whole run needs well under 200 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic do_reset();
		rst = 1'b1;
		repeat (10) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		chk("rdPage", 24'h1, 24'(rdPage));
		chk("wrPage", 24'h1, 24'(wrPage));
	endtask

	task automatic op(input dspea_mode_t m, input logic w, mv, ll,
			input logic [15:0] p, b, f, c, input logic [9:0] l);
		dspea_req_t r;
		r = '{valid: 1'b1, mode: m, isWrite: w, isMove: mv, longLit: ll, ptrSel: 4'h3,
			pointerValue: p, baseOperandValue: b, fileAddr: f, modConst: c, literal: l};
		u_core.send(r);
	endtask

	task automatic set_page(input logic rd, wr, input logic [9:0] d);
		pageWrRead = rd;
		pageWrWrite = wr;
		pageWrData = d;
		@(posedge clk_sys);
		#1;
		pageWrRead = 1'b0;
		pageWrWrite = 1'b0;
		// One quiet edge so back-to-back calls never retouch a strobe in one step
		@(posedge clk_sys);
		#1;
	endtask

	task automatic test_window();
		op(ModeIndirect, 0, 0, 0, 16'h7ffe, 0, 0, 0, 0);
		chk("low ext", 24'h007ffe, rsp.extAddr);
		op(ModeIndirect, 0, 0, 0, 16'h9000, 0, 0, 0, 0);
		chk("page1 ext", 24'h009000, rsp.extAddr);
		u_core.idle();
		set_page(1, 0, 10'h002);
		set_page(0, 1, 10'h003);
		op(ModeIndirect, 0, 0, 0, 16'h8000, 0, 0, 0, 0);
		chk("rd page2", 24'h010000, rsp.extAddr);
		op(ModeIndirect, 1, 0, 0, 16'hffff, 0, 0, 0, 0);
		chk("wr page3", 24'h01ffff, rsp.extAddr);
		op(ModeIndirect, 1, 0, 0, 16'h0004, 0, 0, 0, 0);
		chk("low wr", 24'h000004, rsp.extAddr);
		u_core.idle();
		set_page(1, 1, 10'h000);
		chk("rd kept", 24'h2, 24'(rdPage));
		chk("wr kept", 24'h3, 24'(wrPage));
	endtask

	task automatic test_modes();
		op(ModePostMod, 0, 0, 0, 16'h9000, 0, 0, 16'h0002, 0);
		chk("post ea", 24'h9000, 24'(rsp.effectiveAddress));
		chk("post ext", 24'h011000, rsp.extAddr);
		chk("post new", 24'h9002, 24'(rsp.ptrNewValue));
		chk("post upd", 24'h1, 24'(rsp.ptrUpdate));
		chk("post valid", 24'h1, 24'(rsp.valid));
		chk("post sel", 24'h3, 24'(rsp.ptrSel));
		chk("post trap", 24'h0, 24'(rsp.addrErrorTrap));
		op(ModeRegDirect, 0, 0, 0, 16'h1234, 16'h0042, 0, 0, 0);
		chk("regdir ea", 24'h0042, 24'(rsp.effectiveAddress));
		chk("regdir upd", 24'h0, 24'(rsp.ptrUpdate));
		op(ModePreMod, 0, 0, 0, 16'h1000, 0, 0, 16'hfffe, 0);
		chk("pre ea", 24'h0ffe, 24'(rsp.effectiveAddress));
		op(ModeIndexed, 0, 0, 0, 16'h1000, 16'h0020, 0, 0, 0);
		chk("idx ea", 24'h1020, 24'(rsp.effectiveAddress));
		op(ModeLitOffset, 0, 0, 0, 16'h1000, 0, 0, 0, 10'h005);
		chk("lit off", 24'h1005, 24'(rsp.effectiveAddress));
		op(ModeFileDirect, 0, 0, 0, 0, 0, 16'hffff, 0, 0);
		chk("near ea", 24'h1fff, 24'(rsp.effectiveAddress));
		chk("default_work_register", 24'h0, 24'(rsp.defaultWorkReg));
		op(ModeFileDirect, 0, 1, 0, 0, 0, 16'hffff, 0, 0);
		chk("move ea", 24'hffff, 24'(rsp.effectiveAddress));
		op(ModeLiteral, 0, 0, 0, 0, 0, 0, 0, 10'h3ff);
		chk("lit5", 24'h001f, 24'(rsp.literalValue));
		chk("lit flag", 24'h1, 24'(rsp.isLiteral));
		chk("lit valid", 24'h0, 24'(rsp.valid));
		op(ModeLiteral, 0, 0, 1, 0, 0, 0, 0, 10'h3ff);
		chk("lit10", 24'h03ff, 24'(rsp.literalValue));
		u_core.idle();
	endtask

	initial begin
		do_reset();
		test_window();
		test_modes();
		do_reset();
		give_verdict();
	end
endmodule
